// File: design/cfc_filter_cfg.sv
// Operation
// - Unlock bit 0 locks bank settings, 1 unlocks them.
// - Mode, scale, FIFO and enable registers change only while unlocked.
// - One bit per bank in 27:0; bits 31:28 stay at reset value.
// - Mode bit 0 selects mask matching, 1 selects identifier list.
// - Scale bit 0 gives 16-bit filters, 1 gives 32-bit filters.
// - FIFO bit routes accepted frames to FIFO 0 or FIFO 1.
// - Enable bit 0 leaves bank idle, 1 joins filtering.
// - Each bank has two 32-bit data words with undefined reset contents.
// - Mask mode: data bit 1 compares identifier bit, 0 ignores it.
// - List mode: each data bit gives the exact identifier bit value.
// - Banks below split point serve first controller, the rest the second.
`timescale 1ns/100ps
`default_nettype none
module cfc_filter_cfg (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire cfc_pkg::cfc_axi_req_t   s_req,
    output var  cfc_pkg::cfc_axi_rsp_t   s_rsp,
    input  wire cfc_pkg::cfc_match_req_t m_req,
    output var  cfc_pkg::cfc_match_rsp_t m_rsp
);
    logic        unlock_ff;
    logic [5:0]  split_ff;
    logic [27:0] mode_ff;
    logic [27:0] scale_ff;
    logic [27:0] fifo_ff;
    logic [27:0] active_ff;
    logic [31:0] data_ff [cfc_pkg::NWORD];
    logic        aw_full_ff;
    logic        w_full_ff;
    logic [31:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0]  wstrb_ff;
    logic        do_wr;
    logic        aw_hs;
    logic        w_hs;
    logic        ar_hs;
    logic        nxt_aw_full;
    logic        nxt_w_full;
    logic        nxt_rvalid;
    logic        awready_ff;
    logic        wready_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        arready_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;

    //////////////////////////////////////////////////////////////////////////
    // Shared helpers.

    // Word index of a data word, valid only inside the data window.
    function automatic logic [5:0] word_idx(input logic [31:0] a);
        logic [31:0] off;
        off = a - cfc_pkg::ADDR_DATA;
        return off[7:2];
    endfunction

    function automatic logic in_data(input logic [31:0] a);
        return a >= cfc_pkg::ADDR_DATA && a <= cfc_pkg::ADDR_DLAST && a[1:0] == 2'h0;
    endfunction

    function automatic logic mapped(input logic [31:0] a);
        return a == cfc_pkg::ADDR_CTL || a == cfc_pkg::ADDR_MODE || a == cfc_pkg::ADDR_SCALE
            || a == cfc_pkg::ADDR_FIFO || a == cfc_pkg::ADDR_ACTIVE || in_data(a);
    endfunction

    // One bank's comparison; the 16-bit form of the identifier is its top half.
    // mask and list compare
    function automatic logic bank_hit(input logic list, input logic wide, input logic [31:0] d0,
                                      input logic [31:0] d1, input logic [31:0] id);
        logic [15:0] h;
        h = id[31:16];
        if (wide) begin
            bank_hit = list ? (id == d0 || id == d1) : (((id ^ d0) & d1) == 32'h0000_0000);
        end else if (list) begin
            bank_hit = h == d0[15:0] || h == d0[31:16] || h == d1[15:0] || h == d1[31:16];
        end else begin
            bank_hit = ((h ^ d0[15:0]) & d0[31:16]) == 16'h0000 || ((h ^ d1[15:0]) & d1[31:16]) == 16'h0000;
        end
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Write path: address and data are taken in either order.

    assign aw_hs       = s_req.awvalid && s_rsp.awready;
    assign w_hs        = s_req.wvalid && s_rsp.wready;
    assign do_wr       = aw_full_ff && w_full_ff && !s_rsp.bvalid;
    assign nxt_aw_full = (aw_full_ff || aw_hs) && !do_wr;
    assign nxt_w_full  = (w_full_ff || w_hs) && !do_wr;

    // Each answer has its own flop, so no two processes share the response carrier.
    assign s_rsp = '{awready: awready_ff, wready: wready_ff, bvalid: bvalid_ff, bresp: bresp_ff,
                     arready: arready_ff, rvalid: rvalid_ff, rdata: rdata_ff, rresp: rresp_ff};

    // Channel holding registers; ready drops once a word is held.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_ff <= 1'b0;
            w_full_ff  <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
        end else begin
            aw_full_ff <= nxt_aw_full;
            w_full_ff  <= nxt_w_full;
            awready_ff <= !nxt_aw_full;
            wready_ff  <= !nxt_w_full;
        end
    end

    always_ff @(posedge aclk) begin
        if (aw_hs) begin
            awaddr_ff <= s_req.awaddr;
        end
        if (w_hs) begin
            wdata_ff <= s_req.wdata;
            wstrb_ff <= s_req.wstrb;
        end
    end

    // Write response; partial words are refused rather than merged.
    // word access only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= cfc_pkg::RESP_OKAY;
        end else if (do_wr) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= (mapped(awaddr_ff) && wstrb_ff == cfc_pkg::STRB_WORD) ? cfc_pkg::RESP_OKAY
                                                                              : cfc_pkg::RESP_SLVERR;
        end else if (s_req.bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    logic wr_ok;
    assign wr_ok = do_wr && wstrb_ff == cfc_pkg::STRB_WORD;

    // Global control: unlock bit and split point are never gated.
    // unlock bit store
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            unlock_ff <= cfc_pkg::CTL_RESET[cfc_pkg::UNLOCK_BIT];
            split_ff  <= cfc_pkg::CTL_RESET[cfc_pkg::SPLIT_MSB:cfc_pkg::SPLIT_LSB];
        end else if (wr_ok && awaddr_ff == cfc_pkg::ADDR_CTL) begin
            unlock_ff <= wdata_ff[cfc_pkg::UNLOCK_BIT];
            split_ff  <= wdata_ff[cfc_pkg::SPLIT_MSB:cfc_pkg::SPLIT_LSB];
        end
    end

    // Bank settings; a locked write still answers OKAY but changes nothing.
    // lock gates settings
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_ff   <= cfc_pkg::CFG_RESET;
            scale_ff  <= cfc_pkg::CFG_RESET;
            fifo_ff   <= cfc_pkg::CFG_RESET;
            active_ff <= cfc_pkg::CFG_RESET;
        end else if (wr_ok && unlock_ff) begin
            if (awaddr_ff == cfc_pkg::ADDR_MODE) begin
                mode_ff <= wdata_ff[27:0];
            end
            if (awaddr_ff == cfc_pkg::ADDR_SCALE) begin
                scale_ff <= wdata_ff[27:0];
            end
            if (awaddr_ff == cfc_pkg::ADDR_FIFO) begin
                fifo_ff <= wdata_ff[27:0];
            end
            if (awaddr_ff == cfc_pkg::ADDR_ACTIVE) begin
                active_ff <= wdata_ff[27:0];
            end
        end
    end

    // Data words carry no reset, so they power up unknown.
    // two words per bank
    always_ff @(posedge aclk) begin
        if (wr_ok && in_data(awaddr_ff)) begin
            data_ff[word_idx(awaddr_ff)] <= wdata_ff;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read path: one read in flight, answered at the edge after acceptance.

    assign ar_hs      = s_req.arvalid && s_rsp.arready;
    assign nxt_rvalid = ar_hs || (s_rsp.rvalid && !s_req.rready);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= cfc_pkg::RESP_OKAY;
        end else begin
            arready_ff <= !nxt_rvalid;
            rvalid_ff  <= nxt_rvalid;
            if (ar_hs) begin
                rresp_ff <= mapped(s_req.araddr) ? cfc_pkg::RESP_OKAY : cfc_pkg::RESP_SLVERR;
                unique case (1'b1)
                    s_req.araddr == cfc_pkg::ADDR_CTL: begin
                        rdata_ff <= {cfc_pkg::CTL_RESET[31:14], split_ff, cfc_pkg::CTL_RESET[7:1], unlock_ff};
                    end
                    s_req.araddr == cfc_pkg::ADDR_MODE:   rdata_ff <= {4'h0, mode_ff};
                    s_req.araddr == cfc_pkg::ADDR_SCALE:  rdata_ff <= {4'h0, scale_ff};
                    s_req.araddr == cfc_pkg::ADDR_FIFO:   rdata_ff <= {4'h0, fifo_ff};
                    s_req.araddr == cfc_pkg::ADDR_ACTIVE: rdata_ff <= {4'h0, active_ff};
                    in_data(s_req.araddr):                rdata_ff <= data_ff[word_idx(s_req.araddr)];
                    default:                              rdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Identifier lookup; the lowest numbered passing bank wins.

    logic        any_hit;
    logic [4:0]  hit_bank;
    logic        in_range;

    always_comb begin
        any_hit  = 1'b0;
        hit_bank = 5'h00;
        in_range = 1'b0;
        for (int b = cfc_pkg::NBANK - 1; b >= 0; b--) begin
            in_range = m_req.ctrl ? (b >= int'(split_ff)) : (b < int'(split_ff));
            if (active_ff[b] && in_range
                && bank_hit(mode_ff[b], scale_ff[b], data_ff[2*b], data_ff[2*b+1], m_req.id)) begin
                any_hit  = 1'b1;
                hit_bank = 5'(b);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            m_rsp <= '0;
        end else begin
            m_rsp.valid <= m_req.valid;
            m_rsp.hit   <= m_req.valid && any_hit;
            m_rsp.fifo  <= m_req.valid && any_hit && fifo_ff[hit_bank];
            m_rsp.bank  <= hit_bank;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr_done;
        do_wr ##1 s_rsp.bvalid;
    endsequence

    sequence s_b_held;
        s_rsp.bvalid && !s_req.bready ##1 s_rsp.bvalid;
    endsequence

    a_wr_answer: assert property (do_wr |-> s_wr_done) else $error("write not answered");
    a_b_hold: assert property (s_rsp.bvalid && !s_req.bready |-> s_b_held) else $error("bvalid dropped");
    a_rd_latency: assert property (ar_hs |=> s_rsp.rvalid && !s_rsp.arready) else $error("read late");
    a_partial_err: assert property (do_wr && wstrb_ff != cfc_pkg::STRB_WORD |=> s_rsp.bresp == cfc_pkg::RESP_SLVERR)
        else $error("partial write accepted");
    a_lock_mode: assert property (!$stable(mode_ff) |-> $past(unlock_ff)) else $error("mode changed locked");
    a_lock_active: assert property (do_wr && !unlock_ff |=> $stable(active_ff) && $stable(fifo_ff))
        else $error("settings changed locked");
    a_rsvd_read: assert property (ar_hs && s_req.araddr == cfc_pkg::ADDR_MODE |=> s_rsp.rdata[31:28] == 4'h0)
        else $error("reserved bits set");
    a_hit_active: assert property (m_rsp.hit |-> active_ff[m_rsp.bank]) else $error("idle bank hit");
    a_hit_fifo: assert property (m_rsp.hit |-> m_rsp.fifo == fifo_ff[m_rsp.bank]) else $error("wrong fifo");
    a_split_range: assert property (m_rsp.hit
        |-> ($past(m_req.ctrl) == ({1'b0, m_rsp.bank} >= $past(split_ff))))
        else $error("bank outside range");
    a_mask_wide: assert property (m_rsp.hit && !mode_ff[m_rsp.bank] && scale_ff[m_rsp.bank]
        |-> ((($past(m_req.id) ^ data_ff[2*m_rsp.bank]) & data_ff[2*m_rsp.bank+1]) == 32'h0000_0000))
        else $error("mask miss accepted");
    a_list_wide: assert property (m_rsp.hit && mode_ff[m_rsp.bank] && scale_ff[m_rsp.bank]
        |-> ($past(m_req.id) == data_ff[2*m_rsp.bank] || $past(m_req.id) == data_ff[2*m_rsp.bank+1]))
        else $error("list miss accepted");
    a_match_timing: assert property (m_req.valid |=> m_rsp.valid) else $error("lookup late");
    a_ctl_write: assert property (wr_ok && awaddr_ff == cfc_pkg::ADDR_CTL
        |=> unlock_ff == wdata_ff[cfc_pkg::UNLOCK_BIT]) else $error("unlock bit not stored");
    a_ctl_rsvd: assert property (ar_hs && s_req.araddr == cfc_pkg::ADDR_CTL
        |=> s_rsp.rdata[7:1] == cfc_pkg::CTL_RESET[7:1]) else $error("control reserved bits changed");
    a_b_clear: assert property (s_rsp.bvalid && s_req.bready |=> !s_rsp.bvalid) else $error("bvalid stuck");

endmodule // cfc_filter_cfg
`default_nettype wire

// File: design/cfc_pkg.sv
`default_nettype none
package cfc_pkg;
    localparam int          NBANK       = 28;
    localparam int          NWORD       = 56;
    localparam logic [31:0] ADDR_CTL    = 32'h4000_6600;
    localparam logic [31:0] ADDR_MODE   = 32'h4000_6604;
    localparam logic [31:0] ADDR_SCALE  = 32'h4000_660C;
    localparam logic [31:0] ADDR_FIFO   = 32'h4000_6614;
    localparam logic [31:0] ADDR_ACTIVE = 32'h4000_661C;
    localparam logic [31:0] ADDR_DATA   = 32'h4000_6640;
    localparam logic [31:0] ADDR_DLAST  = 32'h4000_671C;
    localparam logic [31:0] CTL_RESET   = 32'h2A1C_0E01;
    localparam int          UNLOCK_BIT  = 0;
    localparam int          SPLIT_LSB   = 8;
    localparam int          SPLIT_MSB   = 13;
    localparam logic [27:0] CFG_RESET   = 28'h000_0000;
    localparam logic [3:0]  STRB_WORD   = 4'hF;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // Register bus channels, grouped by direction.
    typedef struct packed {
        logic        awvalid;
        logic [31:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [31:0] araddr;
        logic        rready;
    } cfc_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } cfc_axi_rsp_t;

    // Identifier lookup request from the receive side and its answer.
    typedef struct packed {
        logic        valid;
        logic        ctrl;
        logic [31:0] id;
    } cfc_match_req_t;

    typedef struct packed {
        logic        valid;
        logic        hit;
        logic        fifo;
        logic [4:0]  bank;
    } cfc_match_rsp_t;
endpackage
`default_nettype wire

// File: sim/tb_can_acceptance_filter_config.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_can_acceptance_filter_config;
    logic                    aclk;
    logic                    aresetn;
    cfc_pkg::cfc_axi_req_t   s_req;
    cfc_pkg::cfc_axi_rsp_t   s_rsp;
    cfc_pkg::cfc_match_req_t m_req;
    cfc_pkg::cfc_match_rsp_t m_rsp;
    int                      n_mismatch;
    int                      n_compared;
    int                      cyc;
    logic [31:0]             cfg_a [4];
    logic [31:0]             d;
    logic [1:0]              r;

    cfc_filter_cfg u_dut (
        .aclk    (aclk),
        .aresetn (aresetn),
        .s_req   (s_req),
        .s_rsp   (s_rsp),
        .m_req   (m_req),
        .m_rsp   (m_rsp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock and a cycle ceiling, so a stuck handshake cannot hang the run.
    always #2 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Bus tasks start right after an edge; bready and rready stay high throughout.
    task automatic axw(input logic [31:0] a, input logic [31:0] v, input logic [3:0] st, output logic [1:0] rs);
        bit aw_d;
        bit w_d;
        aw_d = 0;
        w_d = 0;
        s_req.awvalid <= 1'b1;
        s_req.awaddr  <= a;
        s_req.wvalid  <= 1'b1;
        s_req.wdata   <= v;
        s_req.wstrb   <= st;
        while (!(aw_d && w_d)) begin
            @(posedge aclk);
            if (!aw_d && s_rsp.awready === 1'b1) begin aw_d = 1; s_req.awvalid <= 1'b0; end
            if (!w_d && s_rsp.wready === 1'b1) begin w_d = 1; s_req.wvalid <= 1'b0; end
        end
        do @(posedge aclk); while (s_rsp.bvalid !== 1'b1);
        rs = s_rsp.bresp;
    endtask

    task automatic axr(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
        s_req.arvalid <= 1'b1;
        s_req.araddr  <= a;
        do @(posedge aclk); while (s_rsp.arready !== 1'b1);
        s_req.arvalid <= 1'b0;
        do @(posedge aclk); while (s_rsp.rvalid !== 1'b1);
        v  = s_rsp.rdata;
        rs = s_rsp.rresp;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        logic [1:0] rs;
        axw(a, v, cfc_pkg::STRB_WORD, rs);
        `CHK("bresp", cfc_pkg::RESP_OKAY, rs)
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] v;
        logic [1:0]  rs;
        axr(a, v, rs);
        `CHK("rresp", cfc_pkg::RESP_OKAY, rs)
        `CHK("rdata", e, v)
    endtask

    // One lookup; the answer stands for a single cycle after the taking edge.
    task automatic lk(input logic c, input logic [31:0] id, input logic hit, input logic ff, input logic [4:0] bk);
        m_req <= '{valid: 1'b1, ctrl: c, id: id};
        @(posedge aclk);
        m_req.valid <= 1'b0;
        #1;
        `CHK("m_valid", 1'b1, m_rsp.valid)
        `CHK("m_hit", hit, m_rsp.hit)
        `CHK("m_fifo", ff, m_rsp.fifo)
        if (hit) `CHK("m_bank", bk, m_rsp.bank)
        @(posedge aclk);
    endtask

    function automatic logic [31:0] da(input int b, input int w);
        return cfc_pkg::ADDR_DATA + 32'(8 * b + 4 * w);
    endfunction

    function automatic logic [31:0] ctl(input logic [5:0] sp, input logic un);
        return {cfc_pkg::CTL_RESET[31:14], sp, cfc_pkg::CTL_RESET[7:1], un};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: register access first, then matching on a small bank set.
    initial begin
        aclk = 0; aresetn = 0; s_req = '0; m_req = '0; s_req.bready = 1'b1; s_req.rready = 1'b1;
        cfg_a = '{cfc_pkg::ADDR_MODE, cfc_pkg::ADDR_SCALE, cfc_pkg::ADDR_FIFO, cfc_pkg::ADDR_ACTIVE};
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(cfc_pkg::ADDR_CTL, cfc_pkg::CTL_RESET);
        // Reserved top nibble must never take a written one.
        foreach (cfg_a[i]) begin
            rd(cfg_a[i], 32'h0000_0000);
            wr(cfg_a[i], 32'hFFFF_FFFF);
            rd(cfg_a[i], 32'h0FFF_FFFF);
            wr(cfg_a[i], 32'h0000_0000);
        end
        axw(cfc_pkg::ADDR_ACTIVE, 32'h0000_0001, 4'h1, r);
        `CHK("strb_resp", cfc_pkg::RESP_SLVERR, r)
        rd(cfc_pkg::ADDR_ACTIVE, 32'h0000_0000);
        axr(32'h4000_6630, d, r);
        `CHK("hole_resp", cfc_pkg::RESP_SLVERR, r)
        `CHK("hole_data", 32'h0000_0000, d)
        // Locked writes answer OKAY but leave every bank setting as it was.
        wr(cfc_pkg::ADDR_CTL, ctl(6'h0E, 1'b0));
        rd(cfc_pkg::ADDR_CTL, ctl(6'h0E, 1'b0));
        foreach (cfg_a[i]) begin
            wr(cfg_a[i], 32'h0000_0005);
            rd(cfg_a[i], 32'h0000_0000);
        end
        wr(cfc_pkg::ADDR_CTL, ctl(6'h0E, 1'b1));
        wr(cfc_pkg::ADDR_DLAST, 32'hA5A5_5A5A);
        rd(da(27, 1), 32'hA5A5_5A5A);
        // Bank 0 mask 32-bit to FIFO 1, bank 1 list 32-bit, bank 2 mask 16-bit.
        wr(da(0, 0), 32'h1234_5678);
        wr(da(0, 1), 32'hFFFF_0000);
        wr(da(1, 0), 32'hAAAA_0000);
        wr(da(1, 1), 32'h5555_0000);
        wr(da(2, 0), 32'hFFFF_4321);
        wr(da(2, 1), 32'hFFFF_FFFF);
        rd(da(0, 0), 32'h1234_5678);
        wr(cfc_pkg::ADDR_SCALE, 32'h0000_0003);
        wr(cfc_pkg::ADDR_MODE, 32'h0000_0002);
        wr(cfc_pkg::ADDR_FIFO, 32'h0000_0001);
        wr(cfc_pkg::ADDR_ACTIVE, 32'h0000_0007);
        lk(1'b0, 32'h1234_ABCD, 1'b1, 1'b1, 5'h00);
        lk(1'b0, 32'h1235_ABCD, 1'b0, 1'b0, 5'h00);
        lk(1'b0, 32'h5555_0000, 1'b1, 1'b0, 5'h01);
        lk(1'b0, 32'h5555_0001, 1'b0, 1'b0, 5'h00);
        lk(1'b0, 32'h4321_0000, 1'b1, 1'b0, 5'h02);
        // Bank 2 briefly in 16-bit list mode: the low half of word 0 is one of its four identifiers.
        wr(cfc_pkg::ADDR_MODE, 32'h0000_0006);
        lk(1'b0, 32'h4321_0000, 1'b1, 1'b0, 5'h02);
        lk(1'b0, 32'h4322_0000, 1'b0, 1'b0, 5'h00);
        wr(cfc_pkg::ADDR_MODE, 32'h0000_0002);
        lk(1'b1, 32'h1234_ABCD, 1'b0, 1'b0, 5'h00);
        wr(cfc_pkg::ADDR_ACTIVE, 32'h0000_0006);
        lk(1'b0, 32'h1234_ABCD, 1'b0, 1'b0, 5'h00);
        wr(cfc_pkg::ADDR_SCALE, 32'h0000_0007);
        lk(1'b0, 32'h4321_0000, 1'b0, 1'b0, 5'h00);
        // Moving the split point hands bank 1 to the second controller.
        wr(cfc_pkg::ADDR_CTL, ctl(6'h01, 1'b1));
        lk(1'b0, 32'h5555_0000, 1'b0, 1'b0, 5'h00);
        lk(1'b1, 32'h5555_0000, 1'b1, 1'b0, 5'h01);
        give_verdict();
    end
endmodule // tb_can_acceptance_filter_config
`undef CHK
`default_nettype wire
